// file: aps_seq.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// paced single / scan conversion sequencer, no fifo
// ==========================================================
module aps_seq
    import aps_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    // register bus
    input wire logic [aps_pkg::ADDR_W-1:0] regAddr,
    input wire logic [aps_pkg::REG_W-1:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [aps_pkg::REG_W-1:0] regRdData,
    // pacing timer
    input wire logic pacingTick,
    input wire logic timerPresent,
    // converter link
    input wire logic convDone,
    input wire logic [aps_pkg::DATA_W-1:0] convData,
    output logic convStart,
    output logic [aps_pkg::CH_W-1:0] convChan,
    // interrupt to host
    output logic adIrq
);
    import aps_pkg::*;

    // ======================================================
    // state of the sequencer
    // ======================================================
    typedef struct packed {
        aps_seq_t seq; // idle or waiting for a result
        logic paced; // conversion in flight came from a tick
        aps_conv_req_t req; // start pulse and its channel
        aps_ctrl_t ctrl; // mode bits and run
        aps_range_t range; // programmed channel range
        logic [NUM_CH-1:0][DATA_W-1:0] result; // last result per channel
        logic [REG_W-1:0] rdData; // read answer, one cycle late
    } aps_seq_state_t;

    aps_seq_state_t q_ff; // registered state
    aps_seq_state_t nxt_q; // next state

    logic ptrLoad; // pointer back to low
    logic ptrAdv; // pointer one step on
    logic [CH_W-1:0] chanPtr; // current pointer
    aps_status_t evtSet; // events into the status register
    aps_status_t status; // sticky status bits
    aps_status_t mask; // interrupt mask
    // decoded control
    logic runOk; // paced acquisition allowed
    logic [1:0] mode; // decoded mode 0..3
    logic softStart; // software conversion request
    logic wrCtrl; // write strobes per register
    logic wrRange;
    logic wrStatus;
    logic wrMask;
    logic [NUM_CH-1:0] resWe; // result write enable per channel
    logic [NUM_CH-1:0][DATA_W-1:0] nxt_result; // per-channel next result

    // ======================================================
    // decode and strobes
    // ======================================================
    // only modes 0..3 exist here; fifo enable halts pacing
    assign mode = {q_ff.ctrl.scanEn, q_ff.ctrl.recycleEn};
    // a missing timer blocks every paced start and so every event
    assign runOk = q_ff.ctrl.run & ~q_ff.ctrl.fifoEn & timerPresent;
    // write strobes
    assign wrCtrl = regWr && (regAddr == OFS_CTRL);
    assign wrRange = regWr && (regAddr == OFS_RANGE);
    assign wrStatus = regWr && (regAddr == OFS_STATUS);
    assign wrMask = regWr && (regAddr == OFS_MASK);
    assign softStart = regWr && (regAddr == OFS_SWCONV);

    // ======================================================
    // result store, one word per channel
    // trade-off: flops, no memory macro
    // ======================================================
    for (genvar c = 0; c < NUM_CH; c++)
    begin : g_res
        assign resWe[c] = (q_ff.seq == SEQ_CONV) && convDone
            && (q_ff.req.chan == CH_W'(c));
        assign nxt_result[c] = resWe[c] ? convData : q_ff.result[c];
    end

    // ======================================================
    // sequencer, register writes and read answer
    // ======================================================
    always_comb
    begin
        nxt_q = q_ff;
        // start is one cycle
        nxt_q.req.start = 1'b0;
        nxt_q.result = nxt_result;
        ptrLoad = 1'b0;
        ptrAdv = 1'b0;
        evtSet = '0;

        // register writes
        if (wrCtrl)
        begin
            nxt_q.ctrl = regWrData[$bits(aps_ctrl_t)-1:0];
        end
        if (wrRange)
        begin
            nxt_q.range.low = regWrData[RANGE_LOW_LSB +: CH_W];
            nxt_q.range.high = regWrData[RANGE_HIGH_LSB +: CH_W];
        end

        // sequencer proper
        case (q_ff.seq)
            SEQ_IDLE:
            begin
                if (runOk && pacingTick)
                begin
                    // paced singles and scans open only here, so spacing is the tick period
                    nxt_q.seq = SEQ_CONV;
                    nxt_q.paced = 1'b1;
                    nxt_q.req.start = 1'b1;
                    if (q_ff.ctrl.scanEn)
                    begin
                        // a scan always opens on the low channel
                        nxt_q.req.chan = q_ff.range.low;
                        ptrLoad = 1'b1;
                    end
                    else
                    begin
                        nxt_q.req.chan = chanPtr;
                    end
                end
                // tick wins over software
                else if (softStart)
                begin
                    // host completes a scan in the first-interrupt variant
                    nxt_q.seq = SEQ_CONV;
                    nxt_q.paced = 1'b0;
                    nxt_q.req.start = 1'b1;
                    nxt_q.req.chan = chanPtr;
                end
            end
            SEQ_CONV:
            begin
                if (runOk && pacingTick)
                begin
                    // tick lost: the previous work is not done yet
                    evtSet[ST_OVR] = 1'b1;
                end
                // overrun kept even on cancel
                if (q_ff.paced && !runOk)
                begin
                    // cancel: drop the conversion, its late result is ignored
                    nxt_q.seq = SEQ_IDLE;
                end
                // done taken only here
                else if (convDone)
                begin
                    if (!q_ff.paced)
                    begin
                        // software conversion raises nothing
                        ptrAdv = 1'b1;
                        nxt_q.seq = SEQ_IDLE;
                    end
                    else if (!q_ff.ctrl.scanEn)
                    begin
                        ptrAdv = 1'b1;
                        evtSet[ST_ADIRQ] = 1'b1;
                        nxt_q.seq = SEQ_IDLE;
                    end
                    else if (q_ff.ctrl.firstIrq)
                    begin
                        // interrupt after the first, host converts the rest
                        ptrAdv = 1'b1;
                        evtSet[ST_ADIRQ] = 1'b1;
                        nxt_q.seq = SEQ_IDLE;
                    end
                    else if (q_ff.req.chan >= q_ff.range.high)
                    begin
                        // last channel done: one event for the whole scan
                        ptrLoad = 1'b1;
                        evtSet[ST_ADIRQ] = 1'b1;
                        nxt_q.seq = SEQ_IDLE;
                    end
                    else
                    begin
                        // next channel of the scan, no event yet
                        ptrAdv = 1'b1;
                        nxt_q.req.start = 1'b1;
                        nxt_q.req.chan = q_ff.req.chan + CH_ONE;
                    end
                end
            end
            default:
            begin
                nxt_q.seq = SEQ_IDLE;
            end
        endcase

        // read answer stands only in the cycle after the strobe
        nxt_q.rdData = '0;
        if (regRd)
        begin
            // result window first
            if ((regAddr & OFS_RESULT_MASK) == OFS_RESULT)
            begin
                nxt_q.rdData = REG_W'(q_ff.result[regAddr[RES_IDX_LSB +: CH_W]]);
            end
            else
            begin
                // named registers
                case (regAddr)
                    OFS_CTRL: nxt_q.rdData = REG_W'(q_ff.ctrl);
                    OFS_RANGE:
                    begin
                        nxt_q.rdData[RANGE_LOW_LSB +: CH_W] = q_ff.range.low;
                        nxt_q.rdData[RANGE_HIGH_LSB +: CH_W] = q_ff.range.high;
                    end
                    OFS_STATUS: nxt_q.rdData = REG_W'(status);
                    OFS_MASK: nxt_q.rdData = REG_W'(mask);
                    OFS_STATE:
                    begin
                        nxt_q.rdData[STATE_PTR_LSB +: CH_W] = chanPtr;
                        nxt_q.rdData[STATE_MODE_LSB +: 2] = mode;
                        nxt_q.rdData[STATE_BUSY] = (q_ff.seq == SEQ_CONV);
                        nxt_q.rdData[STATE_TIMER] = timerPresent;
                    end
                    default: nxt_q.rdData = '0; // unmapped reads zero
                endcase
            end
        end
    end

    // ======================================================
    // state register
    // ======================================================
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            q_ff <= '0;
            // range resets to channel zero
            q_ff.range <= '{high: RST_HIGH, low: RST_LOW};
        end
        else
        begin
            q_ff <= nxt_q;
        end
    end

    // ======================================================
    // channel pointer and interrupt
    // ======================================================
    // wrap rule lives in one place
    aps_chan_ptr u_ptr (
        .core_clk(core_clk),
        .rst(rst),
        .range(q_ff.range),
        .load(ptrLoad),
        .adv(ptrAdv),
        .ptr(chanPtr)
    );

    // clear ones, replace mask
    aps_irq u_irq (
        .core_clk(core_clk),
        .rst(rst),
        .evtSet(evtSet),
        .clrWr(wrStatus),
        .maskWr(wrMask),
        .wrBits(regWrData[ST_W-1:0]),
        .status(status),
        .mask(mask),
        .irq(adIrq)
    );

    // outputs are state bits
    assign regRdData = q_ff.rdData;
    assign convStart = q_ff.req.start;
    assign convChan = q_ff.req.chan;

endmodule : aps_seq
`default_nettype wire

// file: aps_pkg.sv
// ==========================================================
// shared constants and types of the paced scan sequencer
// ==========================================================
package aps_pkg;

    // ======================================================
    // datapath sizes
    // ======================================================
    localparam int CH_W = 4; // channel number width
    localparam int NUM_CH = 16; // channels reachable by the pointer
    localparam int DATA_W = 16; // conversion result width
    localparam int ADDR_W = 8; // register bus address width
    localparam int REG_W = 32; // register bus data width
    localparam int ST_W = 2; // number of sticky status bits

    // ======================================================
    // register byte offsets
    // ======================================================
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00; // mode bits and run
    localparam logic [ADDR_W-1:0] OFS_RANGE = 8'h04; // low and high channel
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h08; // sticky events, write one to clear
    localparam logic [ADDR_W-1:0] OFS_MASK = 8'h0c; // interrupt enables
    localparam logic [ADDR_W-1:0] OFS_STATE = 8'h10; // pointer, mode, busy
    localparam logic [ADDR_W-1:0] OFS_SWCONV = 8'h14; // a write while idle with no tick starts one conversion
    localparam logic [ADDR_W-1:0] OFS_RESULT = 8'h40; // result of channel n at 0x40 + 4n
    localparam logic [ADDR_W-1:0] OFS_RESULT_MASK = 8'hc3; // bits fixed for the result window
    localparam int RES_IDX_LSB = 2; // channel index inside the result address

    // ======================================================
    // field positions
    // ======================================================
    localparam int CTRL_FIFO = 0; // fifo enable, modes 4..7 not built
    localparam int CTRL_SCAN = 1; // scan enable
    localparam int CTRL_RECYC = 2; // recycle enable, host side only
    localparam int CTRL_RUN = 3; // paced acquisition running
    localparam int CTRL_FIRST = 4; // scan interrupt after first conversion
    localparam int RANGE_LOW_LSB = 0; // lowest channel of the range
    localparam int RANGE_HIGH_LSB = 8; // highest channel of the range
    localparam int STATE_PTR_LSB = 0; // channel pointer
    localparam int STATE_MODE_LSB = 8; // decoded mode 0..3
    localparam int STATE_BUSY = 12; // conversion in flight
    localparam int STATE_TIMER = 13; // pacing timer present
    localparam int ST_ADIRQ = 0; // conversion or scan event
    localparam int ST_OVR = 1; // tick lost while still converting

    // ======================================================
    // reset values
    // ======================================================
    localparam logic [CH_W-1:0] RST_LOW = 4'h0;
    localparam logic [CH_W-1:0] RST_HIGH = 4'h0;
    localparam logic [CH_W-1:0] CH_ONE = 4'h1;

    // ======================================================
    // types
    // ======================================================
    typedef struct packed {
        logic firstIrq;
        logic run;
        logic recycleEn;
        logic scanEn;
        logic fifoEn;
    } aps_ctrl_t;

    typedef struct packed {
        logic [CH_W-1:0] high;
        logic [CH_W-1:0] low;
    } aps_range_t;

    typedef struct packed {
        logic start;
        logic [CH_W-1:0] chan;
    } aps_conv_req_t;

    typedef enum logic {SEQ_IDLE, SEQ_CONV} aps_seq_t;

    typedef logic [ST_W-1:0] aps_status_t;

endpackage : aps_pkg

// file: aps_chan_ptr.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// channel pointer: load to low, step up, wrap at high
// ==========================================================
module aps_chan_ptr
    import aps_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire aps_pkg::aps_range_t range,
    input wire logic load,
    input wire logic adv,
    output logic [aps_pkg::CH_W-1:0] ptr
);
    typedef struct packed {
        logic [CH_W-1:0] ptr;
    } aps_ptr_state_t;

    aps_ptr_state_t q_ff; // registered state
    aps_ptr_state_t nxt_q; // next state

    // ======================================================
    // next pointer
    // ======================================================
    always_comb
    begin
        nxt_q = q_ff;
        if (load)
        begin
            nxt_q.ptr = range.low;
        end
        else if (adv)
        begin
            // wrap also when above high, so a shrunk range recovers
            if (q_ff.ptr >= range.high)
            begin
                nxt_q.ptr = range.low;
            end
            else
            begin
                nxt_q.ptr = q_ff.ptr + CH_ONE;
            end
        end
    end

    // ======================================================
    // state register
    // ======================================================
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            q_ff <= '{ptr: RST_LOW};
        end
        else
        begin
            q_ff <= nxt_q;
        end
    end

    assign ptr = q_ff.ptr;

endmodule : aps_chan_ptr
`default_nettype wire

// file: aps_irq.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// sticky status, mask and one level interrupt
// ==========================================================
module aps_irq
    import aps_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire aps_pkg::aps_status_t evtSet,
    input wire logic clrWr,
    input wire logic maskWr,
    input wire aps_pkg::aps_status_t wrBits,
    output aps_pkg::aps_status_t status,
    output aps_pkg::aps_status_t mask,
    output logic irq
);
    typedef struct packed {
        aps_status_t status;
        aps_status_t mask;
        logic irq;
    } aps_irq_state_t;

    aps_irq_state_t q_ff; // registered state
    aps_irq_state_t nxt_q; // next state
    aps_status_t nxt_status; // per-bit next status

    // ======================================================
    // per bit: set beats a clear in the same cycle
    // ======================================================
    for (genvar i = 0; i < ST_W; i++)
    begin : g_bit
        assign nxt_status[i] = evtSet[i] | (q_ff.status[i] & ~(clrWr & wrBits[i]));
    end

    // ======================================================
    // next state
    // ======================================================
    always_comb
    begin
        nxt_q = q_ff;
        nxt_q.status = nxt_status;
        if (maskWr)
        begin
            nxt_q.mask = wrBits;
        end
        // held until software clears the bit or its mask bit
        nxt_q.irq = |(nxt_q.status & nxt_q.mask);
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            q_ff <= '0;
        end
        else
        begin
            q_ff <= nxt_q;
        end
    end

    assign status = q_ff.status;
    assign mask = q_ff.mask;
    assign irq = q_ff.irq;

endmodule : aps_irq
`default_nettype wire

// file: aps_seq_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// port checker of the paced scan sequencer
// ==========================================================
module aps_seq_monitor
    import aps_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [aps_pkg::ADDR_W-1:0] regAddr,
    input wire logic [aps_pkg::REG_W-1:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [aps_pkg::REG_W-1:0] regRdData,
    input wire logic pacingTick,
    input wire logic timerPresent,
    input wire logic convDone,
    input wire logic convStart,
    input wire logic [aps_pkg::CH_W-1:0] convChan,
    input wire logic adIrq
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    // ======================================================
    // helper logic
    // ======================================================
    logic causeSh_ff; // an event was sampled at the last edge
    logic nxt_causeSh;
    // the interrupt flop loads on the same edge as the status bit, so one stage
    always_comb nxt_causeSh = convDone | pacingTick | regWr;
    always_ff @(posedge core_clk) causeSh_ff <= rst ? 1'b0 : nxt_causeSh;

    // ======================================================
    // sequences
    // ======================================================
    sequence s_quiet;
        !convStart;
    endsequence
    // full clear with no event near enough to win against it
    sequence s_clearAll;
        regWr && regAddr == OFS_STATUS && regWrData[1:0] == 2'h3 && !convDone
            && !pacingTick && !$past(convDone) && !$past(pacingTick);
    endsequence

    // ======================================================
    // assertions
    // ======================================================
    a_rd_idle_zero: assert property (!regRd |=> regRdData == '0)
        else $error("read data not zero outside read cycle");
    a_start_one_pulse: assert property (convStart |=> s_quiet)
        else $error("conversion start longer than one cycle");
    a_start_has_cause: assert property (convStart |->
        $past(pacingTick) || $past(convDone) || $past(regWr))
        else $error("conversion started without tick, done or write");
    a_chan_holds: assert property (!convStart |-> $stable(convChan))
        else $error("channel changed without a start");
    a_irq_has_cause: assert property ($rose(adIrq) |-> causeSh_ff)
        else $error("interrupt rose without an event");
    a_irq_held: assert property ($fell(adIrq) |-> $past(regWr))
        else $error("interrupt dropped without a host write");
    a_no_timer_idle: assert property (
        !timerPresent && pacingTick && !convDone && !regWr |=> !convStart)
        else $error("conversion started with no timer");
    a_clear_drops_irq: assert property (s_clearAll |-> ##1 !adIrq)
        else $error("interrupt still high after full clear");
endmodule : aps_seq_monitor

bind aps_seq aps_seq_monitor u_mon (.core_clk, .rst, .regAddr, .regWrData, .regWr,
    .regRd, .regRdData, .pacingTick, .timerPresent, .convDone, .convStart, .convChan,
    .adIrq);
`default_nettype wire

// file: aps_conv_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// converter on the far side: answers each start after a latency
// ==========================================================
module aps_conv_model
    import aps_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [3:0] latency,
    input wire logic convStart,
    input wire logic [aps_pkg::CH_W-1:0] convChan,
    output logic convDone,
    output logic [aps_pkg::DATA_W-1:0] convData
);
    logic [3:0] cnt; // cycles left
    logic busy; // conversion in flight
    logic [aps_pkg::CH_W-1:0] chan; // channel being converted
    // result carries its channel so a misfiled result shows up
    always @(posedge core_clk)
    begin
        convDone <= 1'b0;
        convData <= ~convData; // junk outside the valid cycle
        if (rst)
        begin
            busy <= 1'b0;
            convData <= 16'h0f0f;
        end
        else if (convStart)
        begin
            busy <= 1'b1;
            cnt <= latency;
            chan <= convChan;
        end
        else if (busy && cnt <= 4'h1)
        begin
            busy <= 1'b0;
            convDone <= 1'b1;
            convData <= {12'hc50, chan};
        end
        else if (busy)
            cnt <= cnt - 4'h1;
    end
endmodule : aps_conv_model
`default_nettype wire

// file: tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
    begin \
        compares++; \
        if ((got) !== (exp)) \
        begin \
            n_mismatch++; \
            $display("Error at %0t: got %h expected %h", $time, (got), (exp)); \
        end \
    end
// ==========================================================
// self-checking bench of the paced scan sequencer
// ==========================================================
module tb
    import aps_pkg::*;
;
    logic core_clk, rst, regWr, regRd, pacingTick, timerPresent, convDone, convStart, adIrq;
    logic [ADDR_W-1:0] regAddr;
    logic [REG_W-1:0] regWrData, regRdData;
    logic [DATA_W-1:0] convData;
    logic [CH_W-1:0] convChan;
    logic [3:0] lat; // converter latency
    logic [CH_W-1:0] startQ[$]; // channels of observed starts
    int n_mismatch = 0;
    int compares = 0;
    int ptr = 0; // expected channel pointer

    aps_seq DUT (.core_clk, .rst, .regAddr, .regWrData, .regWr, .regRd, .regRdData,
        .pacingTick, .timerPresent, .convDone, .convData, .convStart, .convChan, .adIrq);
    aps_conv_model u_conv (.core_clk, .rst, .latency(lat), .convStart, .convChan,
        .convDone, .convData);

    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    // log every start with its channel
    always @(posedge core_clk)
        if (convStart === 1'b1)
            startQ.push_back(convChan);

    // ======================================================
    // bus and stimulus tasks, entered just after an edge
    // ======================================================
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge core_clk);
        regWr <= 1'b0;
        @(posedge core_clk);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge core_clk);
        regRd <= 1'b0;
        @(posedge core_clk);
        `CHK(regRdData, exp)
    endtask : rd
    task automatic tick();
        pacingTick <= 1'b1;
        @(posedge core_clk);
        pacingTick <= 1'b0;
        @(posedge core_clk);
    endtask : tick
    task automatic complete_run();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : complete_run
    task automatic waitIrq();
        int k;
        k = 0;
        while (adIrq !== 1'b1 && k < 200)
        begin
            @(posedge core_clk);
            k++;
        end
        if (adIrq !== 1'b1)
        begin
            n_mismatch++;
            $display("Error at %0t: interrupt never came", $time);
            complete_run();
        end
    endtask : waitIrq
    // one tick, then the host reads its results and acknowledges
    task automatic doTick(input logic scan, input int low, input int high);
        int n;
        logic [3:0] c;
        n = scan ? high - low + 1 : 1;
        startQ.delete();
        tick();
        waitIrq();
        `CHK(startQ.size(), n)
        for (int i = 0; i < n; i++)
        begin
            c = 4'(scan ? low + i : ptr);
            `CHK(startQ[i], c)
            rd(OFS_RESULT + {2'h0, c, 2'h0}, {28'h0000c50, c});
            if (!scan)
                ptr = (ptr >= high) ? low : ptr + 1;
        end
        if (scan)
            ptr = low;
        wr(OFS_STATUS, 32'h1);
        repeat (2) @(posedge core_clk);
        `CHK(adIrq, 1'b0)
    endtask : doTick

    // ======================================================
    // scenarios
    // ======================================================
    task automatic t_reset();
        rd(OFS_CTRL, 32'h0);
        rd(OFS_RANGE, 32'h0);
        rd(OFS_STATUS, 32'h0);
        rd(OFS_MASK, 32'h0);
        rd(OFS_STATE, 32'h2000);
        rd(8'h20, 32'h0);
        $display("test reset done");
    endtask : t_reset
    // all four modes, pointer wraps across mode changes
    task automatic t_modes();
        wr(OFS_RANGE, 32'h0200);
        wr(OFS_MASK, 32'h1);
        for (int m = 0; m < 4; m++)
        begin
            lat <= m[1] ? 4'h5 : 4'h1;
            wr(OFS_CTRL, 32'h8 | (m[1] << 1) | (m[0] << 2));
            rd(OFS_STATE, 32'h2000 | (m << 8) | ptr);
            doTick(m[1], 0, 2);
            doTick(m[1], 0, 2);
        end
        wr(OFS_CTRL, 32'h0);
        $display("test modes done");
    endtask : t_modes
    // scan interrupt after the first conversion, host finishes the scan
    task automatic t_first();
        wr(OFS_CTRL, 32'h1a);
        startQ.delete();
        tick();
        waitIrq();
        wr(OFS_STATUS, 32'h1);
        wr(OFS_SWCONV, 32'h0);
        repeat (12) @(posedge core_clk);
        wr(OFS_SWCONV, 32'h0);
        repeat (12) @(posedge core_clk);
        `CHK(startQ.size(), 3)
        `CHK(startQ[2], 4'h2)
        rd(OFS_STATUS, 32'h0);
        wr(OFS_CTRL, 32'h0);
        $display("test first done");
    endtask : t_first
    // no timer, then fifo mode: ticks must do nothing
    task automatic t_quiet();
        startQ.delete();
        timerPresent <= 1'b0;
        wr(OFS_CTRL, 32'h8);
        tick();
        repeat (10) @(posedge core_clk);
        timerPresent <= 1'b1;
        wr(OFS_CTRL, 32'h9);
        tick();
        repeat (10) @(posedge core_clk);
        `CHK(startQ.size(), 0)
        rd(OFS_STATUS, 32'h0);
        wr(OFS_CTRL, 32'h0);
        $display("test quiet done");
    endtask : t_quiet
    // tick while busy, then cancel mid conversion
    task automatic t_cancel();
        lat <= 4'hc;
        wr(OFS_CTRL, 32'h8);
        tick();
        tick();
        wr(OFS_CTRL, 32'h0);
        repeat (20) @(posedge core_clk);
        rd(OFS_STATUS, 32'h2);
        `CHK(adIrq, 1'b0)
        wr(OFS_MASK, 32'h3);
        waitIrq();
        wr(OFS_STATUS, 32'h3);
        repeat (2) @(posedge core_clk);
        `CHK(adIrq, 1'b0)
        $display("test cancel done");
    endtask : t_cancel

    initial
    begin
        rst = 1'b1;
        regAddr = '0;
        regWrData = '0;
        regWr = 1'b0;
        regRd = 1'b0;
        pacingTick = 1'b0;
        timerPresent = 1'b1;
        lat = 4'h1;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        t_reset();
        t_modes();
        t_first();
        t_quiet();
        t_cancel();
        complete_run();
    end
endmodule : tb
`default_nettype wire
